// *** design/swd_pkg.sv ***
// Shared constants and types for the serial wiper step-down command link.
// Assumes both ends, the checker and the bench import this package; the interface does not.
package swd_pkg;
	// Command byte layout, first bit on the wire is bit 7.
	localparam int CMD_BITS        = 8;
	localparam int ADDR_MSB        = 7;
	localparam int ADDR_LSB        = 4;
	localparam int OPC_MSB         = 3;
	localparam int OPC_LSB         = 2;
	localparam int ERR_BIT_INDEX   = 6;
	localparam logic [3:0] WIPER_ADDR     = 4'h0;
	localparam logic [1:0] STEP_DOWN_OPCODE = 2'h2;
	localparam logic [1:0] STEP_UP_OPCODE   = 2'h1;
	// Wiper width and value after reset (mid-scale of the 8-bit variant).
	localparam int WIPER_WIDTH     = 8;
	localparam logic [7:0] WIPER_RESET = 8'h80;
	// Host serial clock half period in system clock cycles.
	localparam int SCK_HALF_CYCLES = 10;
	// Idle cycles with chip select high between frames, host side.
	localparam int CS_GAP_CYCLES   = 4;
	// Bit counter type.
	typedef logic [3:0] swd_count_type;
endpackage

// *** design/swd_link_if.sv ***
// Interface joining the host end and the potentiometer end of the serial link.
// Assumes the bench drives no pins itself; data out is driven only by the device.
`timescale 1ns/1ps
interface swd_link_if;
	logic cs_n;
	logic sck;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	// Pull-up on the shared data out line when the device leaves it undriven.
	logic sdo_line;
	assign sdo_line = sdo_oe ? sdo : 1'b1;
	modport device (input cs_n, input sck, input sdi, output sdo, output sdo_oe);
	modport host   (output cs_n, output sck, output sdi, input sdo_line);
endinterface

// *** design/swd_sync.sv ***
// Two-flop synchroniser for a group of single-bit levels from outside the clock.
// Assumes inputs are asynchronous to clk_sys; outputs are safe to read by any logic.
`timescale 1ns/1ps
module swd_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// Levels.
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// First stage feeds only the second stage, never other logic.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// *** design/swd_device.sv ***
// Potentiometer end: decodes serial command bytes and steps the volatile wiper down.
// Assumes the host uses mode 0 timing: data sampled on rising, shifted on falling sck.
//
// Overview of operation
// - Step-down is one eight-clock command byte only.
// - Only wiper address accepted; others are errors.
// - Wiper moves at eighth clock of good byte.
// - Each accepted step-down command lowers a nonzero wiper by one; step-up is accepted but ignored.
// - Seventh clock drives error bit on data out.
// - At zero-scale the wiper stays at zero.
// - Full-scale is all ones of wiper width.
// - Host holds chip select low whole byte.
// - Back-to-back bytes each step once until an error.
// - Other valid commands may follow in frame.
// - Host releases chip select soon after last.
// - After error, data out low until release.
// - Start from idle or within active frame.
`timescale 1ns/1ps
module swd_device
	import swd_pkg::*;
#(
	parameter int WIDTH = swd_pkg::WIPER_WIDTH
) (
	// Clock and reset.
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// Serial link.
	swd_link_if.device            link,
	// User side.
	output logic      [WIDTH-1:0] wiper_value,
	output logic                  step_pulse,
	output logic                  command_error_flag
);
	import swd_pkg::*;

	localparam logic [WIDTH-1:0] FULL_SCALE = {WIDTH{1'b1}};

	typedef enum logic [2:0] {
		SWD_IDLE  = 3'b001,
		SWD_SHIFT = 3'b010,
		SWD_ERROR = 3'b100
	} swd_state_type;

	logic [2:0]            pins_sync;
	logic                  cs_n_s;
	logic                  sck_s;
	logic                  sdi_s;
	logic                  sck_prev_reg;
	logic [1:0]            settle_reg;
	logic                  rise;
	logic                  fall;
	logic                  active;
	swd_state_type         state_reg;
	swd_count_type         count_reg;
	logic [CMD_BITS-1:0]   shift_reg;
	logic                  valid_reg;
	logic [CMD_BITS-1:0]   full_byte;
	logic                  byte_done;
	logic                  cmd_ok;
	logic [WIDTH-1:0]      wiper_reg;

	// Pins cross into clk_sys through two flops before anything reads them.
	swd_sync #(.WIDTH(3)) swd_sync_inst (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.async_in ({link.cs_n, link.sck, link.sdi}),
		.sync_out (pins_sync)
	);
	assign cs_n_s = pins_sync[2];
	assign sck_s  = pins_sync[1];
	assign sdi_s  = pins_sync[0];

	// Edge detection on the synchronised serial clock.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sck_prev_reg <= 1'b0;
		end else begin
			sck_prev_reg <= sck_s;
		end
	end
	assign rise   = sck_s & ~sck_prev_reg;
	assign fall   = ~sck_s & sck_prev_reg;
	assign active = ~cs_n_s & settle_reg[1];

	// The synchroniser clears to zero in reset, which would read as selected.
	// The pins count only once both stages hold real samples, or data out would wake
	// for two cycles after every reset with no host asking.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			settle_reg <= 2'b00;
		end else begin
			settle_reg <= {settle_reg[0], 1'b1};
		end
	end

	// Address and opcode check on the first six bits of the byte.
	function automatic logic check_cmd(input logic [CMD_BITS-1:0] b);
		check_cmd = (b[ADDR_MSB:ADDR_LSB] == WIPER_ADDR) &&
			(b[OPC_MSB:OPC_LSB] == STEP_DOWN_OPCODE ||
			 b[OPC_MSB:OPC_LSB] == STEP_UP_OPCODE);
	endfunction

	// Saturating step down: zero-scale holds, any other value loses exactly one step.
	function automatic logic [WIDTH-1:0] step_down(input logic [WIDTH-1:0] v);
		if (v != '0 && v <= FULL_SCALE) begin
			step_down = v - WIDTH'(1);
		end else begin
			step_down = v;
		end
	endfunction

	assign full_byte = {shift_reg[CMD_BITS-2:0], sdi_s};
	assign byte_done = (state_reg == SWD_SHIFT) && active && rise &&
		(count_reg == swd_count_type'(CMD_BITS - 1));
	assign cmd_ok    = valid_reg && (full_byte[OPC_MSB:OPC_LSB] == STEP_DOWN_OPCODE);

	// Frame state: shifting bytes, or latched error until chip select rises.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= SWD_IDLE;
		end else if (!active) begin
			state_reg <= SWD_IDLE;
		end else begin
			unique case (state_reg)
				SWD_IDLE: begin
					state_reg <= SWD_SHIFT;
				end
				SWD_SHIFT: begin
					// Error is decided once six bits are in, at the sixth rise.
					if (rise && count_reg == swd_count_type'(ERR_BIT_INDEX - 1) &&
						!check_cmd({shift_reg[4:0], sdi_s, 2'b00})) begin
						state_reg <= SWD_ERROR;
					end
				end
				SWD_ERROR: begin
					state_reg <= SWD_ERROR;
				end
				default: begin
					state_reg <= SWD_IDLE;
				end
			endcase
		end
	end

	// Bit counter and shifter, restarting at every byte so bytes chain in a frame.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			count_reg <= '0;
			shift_reg <= '0;
		end else if (!active || state_reg == SWD_IDLE) begin
			count_reg <= '0;
			shift_reg <= '0;
		end else if (rise) begin
			shift_reg <= full_byte;
			if (count_reg == swd_count_type'(CMD_BITS - 1)) begin
				count_reg <= '0;
			end else begin
				count_reg <= count_reg + swd_count_type'(1);
			end
		end
	end

	// Validity of the current byte, known after its sixth bit.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			valid_reg <= 1'b0;
		end else if (!active || state_reg != SWD_SHIFT) begin
			valid_reg <= 1'b0;
		end else if (rise && count_reg == swd_count_type'(ERR_BIT_INDEX - 1)) begin
			valid_reg <= check_cmd({shift_reg[4:0], sdi_s, 2'b00});
		end
	end

	// Wiper update on the eighth rising edge; saturates at zero-scale.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wiper_reg  <= WIPER_RESET[WIDTH-1:0];
			step_pulse <= 1'b0;
		end else begin
			step_pulse <= 1'b0;
			if (byte_done && cmd_ok) begin
				step_pulse <= 1'b1;
				wiper_reg  <= step_down(wiper_reg);
			end
		end
	end
	assign wiper_value = wiper_reg;

	// Data out: high during address bits, error bit from the seventh clock on.
	// Updated on the falling edge so the host samples it on the next rise.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			link.sdo           <= 1'b1;
			link.sdo_oe        <= 1'b0;
			command_error_flag <= 1'b0;
		end else if (!active) begin
			link.sdo           <= 1'b1;
			link.sdo_oe        <= 1'b0;
			command_error_flag <= 1'b0;
		end else begin
			link.sdo_oe <= 1'b1;
			if (state_reg == SWD_ERROR) begin
				command_error_flag <= 1'b1;
				if (fall) begin
					link.sdo <= 1'b0;
				end
			end else if (fall && count_reg == swd_count_type'(ERR_BIT_INDEX)) begin
				link.sdo <= 1'b1;
			end else if (fall) begin
				link.sdo <= 1'b1;
			end
		end
	end
endmodule

// *** design/swd_host.sv ***
// Host end: sends step-down bytes on request, making the serial clock by division.
// Assumes requests come from logic on clk_sys; a frame closes when no more are pending.
`timescale 1ns/1ps
module swd_host
	import swd_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Serial link.
	swd_link_if.host        link,
	// User side.
	input  wire logic       req_valid,
	input  wire logic [3:0] req_addr,
	input  wire logic       req_more,
	output logic            req_ready,
	output logic            done_pulse,
	output logic            command_error_flag
);
	import swd_pkg::*;

	typedef enum logic [2:0] {
		SWH_IDLE = 3'b001,
		SWH_XFER = 3'b010,
		SWH_GAP  = 3'b100
	} swh_state_type;

	swh_state_type   state_reg;
	logic [1:0]      sdo_sync_reg;
	logic [7:0]      div_reg;
	logic            tick;
	swd_count_type   bit_reg;
	logic [7:0]      tx_reg;
	logic            more_reg;

	// Data out from the device is another domain: two flops first.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sdo_sync_reg <= 2'b11;
		end else begin
			sdo_sync_reg <= {sdo_sync_reg[0], link.sdo_line};
		end
	end

	// Half-period enable for the serial clock.
	always_ff @(posedge clk_sys) begin
		if (rst || state_reg != SWH_XFER) begin
			div_reg <= '0;
		end else if (div_reg == 8'(SCK_HALF_CYCLES - 1)) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end
	assign tick = (state_reg == SWH_XFER) && (div_reg == 8'(SCK_HALF_CYCLES - 1));

	// Frame sequencing: one byte per request, frame kept open while more follow.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg          <= SWH_IDLE;
			link.cs_n          <= 1'b1;
			link.sck           <= 1'b0;
			link.sdi           <= 1'b0;
			req_ready          <= 1'b1;
			done_pulse         <= 1'b0;
			command_error_flag <= 1'b0;
			bit_reg            <= '0;
			tx_reg             <= '0;
			more_reg           <= 1'b0;
		end else begin
			done_pulse <= 1'b0;
			unique case (state_reg)
				SWH_IDLE: begin
					if (req_valid && req_ready) begin
						// Address, step-down opcode, two ignored bits.
						tx_reg             <= {req_addr, STEP_DOWN_OPCODE, 2'b00};
						link.sdi           <= req_addr[3];
						more_reg           <= req_more;
						link.cs_n          <= 1'b0;
						req_ready          <= 1'b0;
						bit_reg            <= '0;
						command_error_flag <= 1'b0;
						state_reg          <= SWH_XFER;
					end
				end
				SWH_XFER: begin
					if (tick && !link.sck) begin
						link.sck <= 1'b1;
						if (bit_reg == swd_count_type'(ERR_BIT_INDEX) && !sdo_sync_reg[1]) begin
							command_error_flag <= 1'b1;
						end
					end else if (tick) begin
						link.sck <= 1'b0;
						if (bit_reg == swd_count_type'(CMD_BITS - 1)) begin
							done_pulse <= 1'b1;
							if (more_reg && req_valid) begin
								// Next byte in the same frame, back to back.
								tx_reg   <= {req_addr, STEP_DOWN_OPCODE, 2'b00};
								link.sdi <= req_addr[3];
								more_reg <= req_more;
								bit_reg  <= '0;
							end else begin
								link.cs_n <= 1'b1;
								state_reg <= SWH_GAP;
								bit_reg   <= '0;
							end
						end else begin
							tx_reg   <= {tx_reg[6:0], 1'b0};
							link.sdi <= tx_reg[6];
							bit_reg  <= bit_reg + swd_count_type'(1);
						end
					end
				end
				SWH_GAP: begin
					if (bit_reg == swd_count_type'(CS_GAP_CYCLES - 1)) begin
						req_ready <= 1'b1;
						state_reg <= SWH_IDLE;
					end else begin
						bit_reg <= bit_reg + swd_count_type'(1);
					end
				end
				default: begin
					state_reg <= SWH_IDLE;
				end
			endcase
		end
	end
endmodule

// *** bench/swd_link_properties.sv ***
// Checker on the serial link wires between the host end and the device end.
// Assumes the bench top instantiates it beside the interface, on clk_sys and rst.
`timescale 1ns/1ps
module swd_link_properties (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Link wires.
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic sdo_line
);
	import swd_pkg::*;
	logic       sck_reg;
	logic [2:0] cnt_reg;
	logic [5:0] sh_reg;
	logic       err_reg;
	logic       rise;
	logic       ok;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Edge and byte decode; only address and opcode decide validity.
	assign rise = sck && !sck_reg;
	assign ok = (sh_reg[5:2] == WIPER_ADDR) && (sh_reg[1:0] == 2'h2 || sh_reg[1:0] == 2'h1);
	// Serial clock delayed by one system clock for edge finding.
	always_ff @(posedge clk_sys) begin
		sck_reg <= sck;
	end
	// Bit position in the byte; wraps so back-to-back bytes restart at zero.
	always_ff @(posedge clk_sys) begin
		if (rst || cs_n) begin
			cnt_reg <= 3'h0;
		end else if (rise) begin
			cnt_reg <= cnt_reg + 3'h1;
		end
	end
	// Address and opcode bits of the current byte.
	always_ff @(posedge clk_sys) begin
		if (rise && cnt_reg < 3'h6) begin
			sh_reg <= {sh_reg[4:0], sdi};
		end
	end
	// Error seen at the seventh rise is kept until deselect.
	always_ff @(posedge clk_sys) begin
		if (rst || cs_n) begin
			err_reg <= 1'b0;
		end else if (rise && cnt_reg == 3'h6 && !sdo_line) begin
			err_reg <= 1'b1;
		end
	end
	AST_SCK_IDLE: assert property (cs_n |-> !sck)
		else $error("serial clock high while deselected");
	AST_BYTE_WHOLE: assert property ($rose(cs_n) |-> cnt_reg == 3'h0)
		else $error("frame ended inside a byte");
	AST_SDO_HIGH: assert property (rise && cnt_reg != 3'h6 && !err_reg |-> sdo_line)
		else $error("data out low outside the error bit");
	AST_ERR_BIT: assert property (rise && cnt_reg == 3'h6 && !err_reg |-> sdo_line == ok)
		else $error("error bit disagrees with address and opcode");
	AST_ERR_LOW: assert property (rise && err_reg |-> !sdo_line)
		else $error("data out not low after an error");
	AST_OE_RELEASE: assert property (cs_n && $past(cs_n, 4) |-> !sdo_oe)
		else $error("data out still driven after deselect");
	AST_SDI_STABLE: assert property (!cs_n && sck && $past(sck) |-> $stable(sdi))
		else $error("data in moved while serial clock high");
	AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n [*4])
		else $error("chip select gap too short");
	AST_OE_DRIVE: assert property (!cs_n && !$past(cs_n, 4) |-> sdo_oe)
		else $error("data out not driven while selected");
	AST_SDO_IDLE: assert property (cs_n && $past(cs_n, 4) |-> sdo)
		else $error("data out register not high after deselect");
endmodule

// *** bench/spi_wiper_decrement_cmd_tb.sv ***
// Bench joining host end and device end; drives host requests, checks the wiper.
// Assumes default widths and one step-down byte per host request.
`timescale 1ns/1ps
module spi_wiper_decrement_cmd_tb;
	import swd_pkg::*;
	logic       clk_sys;
	logic       rst;
	logic       req_valid;
	logic [3:0] req_addr;
	logic       req_more;
	logic       req_ready;
	logic       done_pulse;
	logic       host_err;
	logic       dev_err;
	logic       step_pulse;
	logic [7:0] wiper_value;
	logic [7:0] exp_wiper;
	int         error_cnt;
	int         checked;
	int         steps;
	int         exp_steps;
	swd_link_if link ();
	swd_host swd_host_inst (.clk_sys(clk_sys), .rst(rst), .link(link), .req_valid(req_valid),
		.req_addr(req_addr), .req_more(req_more), .req_ready(req_ready),
		.done_pulse(done_pulse), .command_error_flag(host_err));
	swd_device swd_device_inst (.clk_sys(clk_sys), .rst(rst), .link(link),
		.wiper_value(wiper_value), .step_pulse(step_pulse), .command_error_flag(dev_err));
	swd_link_properties swd_link_properties_inst (.clk_sys(clk_sys), .rst(rst),
		.cs_n(link.cs_n), .sck(link.sck), .sdi(link.sdi), .sdo(link.sdo),
		.sdo_oe(link.sdo_oe), .sdo_line(link.sdo_line));
	// Free-running system clock.
	initial clk_sys = 1'b0;
	always #4 clk_sys = ~clk_sys;
	// Steps are counted apart so a saturated step still shows.
	always @(posedge clk_sys) begin
		if (step_pulse === 1'b1) begin
			steps++;
		end
	end
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (exp !== got) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic final_report();
		if (error_cnt == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// One frame of chained bytes; later bytes after an error must do nothing.
	task automatic frame(input logic [3:0] addrs[$]);
		int   n;
		logic err;
		err = 1'b0;
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_addr = addrs[0];
		req_more = addrs.size() > 1;
		n = 0;
		while (req_ready !== 1'b1 && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		check("ready wait", 1'b1, req_ready);
		foreach (addrs[i]) begin
			@(negedge clk_sys);
			req_valid = i + 1 < addrs.size();
			req_addr = req_valid ? addrs[i + 1] : 4'h0;
			req_more = i + 2 < addrs.size();
			n = 0;
			while (done_pulse !== 1'b1 && n < 400) begin
				@(negedge clk_sys);
				n++;
			end
			check("byte done", 1'b1, done_pulse);
			check("select released", i + 1 == addrs.size(), link.cs_n);
			if (addrs[i] == WIPER_ADDR && !err) begin
				exp_steps++;
				exp_wiper = (exp_wiper == 8'h00) ? 8'h00 : exp_wiper - 8'h01;
			end else begin
				err = 1'b1;
			end
			check("wiper", exp_wiper, wiper_value);
			check("steps", exp_steps, steps);
			check("device error", err, dev_err);
			check("host error", err, host_err);
		end
		repeat (10) @(negedge clk_sys);
		check("error cleared", 1'b0, dev_err);
	endtask
	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req_addr = 4'h0;
		req_more = 1'b0;
		exp_wiper = WIPER_RESET;
		repeat (20) @(negedge clk_sys);
		rst = 1'b0;
		check("reset wiper", WIPER_RESET, wiper_value);
		frame('{4'h0});
		frame('{4'h0, 4'h0, 4'h0});
		frame('{4'h0, 4'h5, 4'h0});
		frame('{4'h0, 4'h0});
		for (int a = 1; a < 16; a++) begin
			frame('{a[3:0]});
		end
		while (exp_wiper != 8'h00) begin
			frame('{4'h0, 4'h0, 4'h0, 4'h0});
		end
		frame('{4'h0, 4'h0});
		final_report();
	end
	// Watchdog well beyond the expected run of about 25000 cycles.
	initial begin
		repeat (60000) @(posedge clk_sys);
		error_cnt++;
		final_report();
	end
endmodule
